// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import usf_pkg::*;
;
  // Stimulus
  logic core_clk = 0, nrst = 0, spec = 0, irq_en = 0, irda_en = 0, rx_invert = 0;
  logic char_wr = 0, flag_clr = 0, rx_char_valid = 0, txf_valid = 0, baud16_tick = 0;
  logic tx_nrz = 1, tx_bit_start = 0, rx_pin = 1, rx_pin_peer = 1, tx_idle = 1;
  logic sleep_en = 0, peer_sleep_en = 0, own_irq = 0, peer_irq = 0, m_delta = 0;
  logic thr_write = 0, m_change = 0;
  usf_fc_mode_t rx_fc = USF_FC_OFF, tx_fc = USF_FC_OFF;
  logic [1:0] word_len = 2'h3, trig = 2'h0, char_sel = 2'h0;
  logic [7:0] char_wdata = 8'h00, rx_char = 8'h00, txf_data = 8'h41;
  logic [4:0] rx_fill = 5'h00;
  // Observed
  logic pause_flag, pause_irq, tx_halted, rxf_push, txf_pop, sh_valid, sh_ready;
  logic tx_pin, rx_decoded, osc_run, asleep, pushed;
  logic [7:0] rxf_data, sh_data, far_last, far_cnt, got;
  int   n_errors = 0, n_checks = 0, hi;

  usf_top dut (.core_clk(core_clk), .nrst(nrst), .rx_fc_mode(rx_fc), .tx_fc_mode(tx_fc),
    .special_det_en(spec), .pause_irq_en(irq_en), .word_len(word_len), .rx_trig_sel(trig),
    .irda_en(irda_en), .rx_invert(rx_invert), .char_wr(char_wr), .char_sel(char_sel),
    .char_wdata(char_wdata), .flag_clr(flag_clr), .pause_flag(pause_flag), .pause_irq(pause_irq),
    .tx_halted(tx_halted), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_fill(rx_fill),
    .rxf_push(rxf_push), .rxf_data(rxf_data), .txf_valid(txf_valid), .txf_data(txf_data),
    .txf_pop(txf_pop), .sh_ready(sh_ready), .baud16_tick(baud16_tick), .tx_nrz(tx_nrz),
    .tx_bit_start(tx_bit_start), .sh_valid(sh_valid), .sh_data(sh_data), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .rx_decoded(rx_decoded), .sleep_en(sleep_en), .peer_sleep_en(peer_sleep_en),
    .own_irq_pending(own_irq), .peer_irq_pending(peer_irq), .modem_delta_any(m_delta),
    .rx_pin_peer(rx_pin_peer), .thr_write(thr_write), .modem_in_change(m_change),
    .tx_idle(tx_idle), .osc_run(osc_run), .asleep(asleep));
  usf_far_model far (.core_clk(core_clk), .nrst(nrst), .sh_valid(sh_valid), .sh_data(sh_data),
    .sh_ready(sh_ready), .last_q(far_last), .cnt_q(far_cnt));

  // ----------------------------------------
  // Clock, bit tick and transmit FIFO head
  // ----------------------------------------
  initial forever #2.5 core_clk = ~core_clk;
  // Tick every other cycle keeps char times short
  always @(posedge core_clk) baud16_tick <= ~baud16_tick;
  // Head leaves once popped
  always @(posedge core_clk) if (txf_pop === 1'b1) txf_valid <= 1'b0;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ends on an edge; reads there see the values that stood before it
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Reset six times per run is deliberate: every test starts clean
  task automatic do_reset();
    @(posedge core_clk);
    nrst <= 0;
    {spec, irq_en, irda_en, rx_invert, sleep_en, peer_sleep_en} <= '0;
    rx_fc <= USF_FC_OFF;
    tx_fc <= USF_FC_OFF;
    word_len <= 2'h3;
    cyc(2);
    nrst <= 1;
    cyc(1);
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] v);
    @(posedge core_clk);
    {char_wr, char_sel, char_wdata} <= {1'b1, s, v};
    @(posedge core_clk);
    char_wr <= 0;
  endtask
  // One char in, then watch three cycles for a push
  task automatic rx(input logic [7:0] c);
    pushed = 0;
    @(posedge core_clk);
    {rx_char_valid, rx_char} <= {1'b1, c};
    @(posedge core_clk);
    rx_char_valid <= 0;
    repeat (3) begin
      if (rxf_push === 1'b1) {pushed, got} = {1'b1, rxf_data};
      @(posedge core_clk);
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  task automatic t_pause();
    do_reset();
    rx_fc <= USF_FC_SINGLE;
    rx(8'h00);
    chk(pause_flag, 1);
    do_reset();
    rx_fc <= USF_FC_SINGLE;
    {irq_en, word_len} <= {1'b1, 2'h0};
    wr(2'h0, 8'h13);
    wr(2'h2, 8'h11);
    rx(8'hf3);  // Upper three bits differ
    chk(pushed, 0);
    chk({pause_flag, pause_irq, tx_halted}, 8'h07);
    txf_valid <= 1;
    cyc(10);
    chk(far_cnt, 0);
    rx(8'h11);
    chk(pause_flag, 0);
    cyc(10);
    chk(far_last, 8'h41);
    chk(txf_valid, 0);
    rx_fc <= USF_FC_DOUBLE;
    word_len <= 2'h1;
    wr(2'h1, 8'h14);
    rx(8'h53);
    rx(8'h54);
    chk({pushed, pause_flag}, 8'h01);
    $display("test pause done");
  endtask
  task automatic t_special();
    do_reset();
    spec <= 1;
    rx_fc <= USF_FC_SINGLE;
    wr(2'h1, 8'h55);
    rx(8'h55);
    chk(pushed, 1);
    chk(got, 8'h55);
    chk(pause_flag, 1);
    // Status read side effect clears the flag
    flag_clr <= 1;
    @(posedge core_clk);
    flag_clr <= 0;
    cyc(1);
    chk(pause_flag, 0);
    $display("test special done");
  endtask
  task automatic t_gen();
    do_reset();
    tx_fc <= USF_FC_SINGLE;
    {trig, word_len} <= {2'h1, 2'h0};
    wr(2'h0, 8'h13);
    wr(2'h2, 8'h11);
    rx_fill <= 5'h04;
    cyc(400);
    chk(far_cnt, 0);
    cyc(200);
    chk(far_last, 8'h13);
    rx_fill <= 5'h02;
    cyc(50);
    chk(far_cnt, 1);
    rx_fill <= 5'h01;
    cyc(50);
    chk({far_cnt[3:0], far_last[3:0]}, 8'h21);
    $display("test generate done");
  endtask
  task automatic t_ir();
    do_reset();
    irda_en <= 1;
    cyc(4);
    chk(tx_pin, 0);
    // A one bit must leave the line dark
    {tx_nrz, tx_bit_start} <= 2'b11;
    @(posedge core_clk);
    tx_bit_start <= 0;
    cyc(2);
    chk(tx_pin, 0);
    {tx_nrz, tx_bit_start} <= 2'b01;
    @(posedge core_clk);
    {tx_nrz, tx_bit_start} <= 2'b10;
    hi = 0;
    repeat (20) begin
      if (tx_pin === 1'b1 && baud16_tick === 1'b1) hi++;
      @(posedge core_clk);
    end
    chk(hi, 3);
    rx_pin <= 0;
    cyc(60);
    chk(rx_decoded, 0);
    rx_pin <= 1;
    cyc(3);
    chk(rx_decoded, 1);
    rx_invert <= 1;
    cyc(60);
    chk(rx_decoded, 0);
    rx_pin <= 0;
    cyc(3);
    chk(rx_decoded, 1);
    rx_pin <= 1;
    $display("test infrared done");
  endtask
  task automatic t_sleep();
    do_reset();
    {sleep_en, peer_sleep_en} <= 2'b11;
    cyc(3);
    chk({asleep, osc_run}, 8'h02);
    {thr_write, own_irq} <= 2'b11;
    cyc(1);
    thr_write <= 0;
    cyc(4);
    chk(asleep, 0);
    own_irq <= 0;
    cyc(3);
    chk(asleep, 1);
    {m_change, m_delta} <= 2'b11;
    cyc(1);
    m_change <= 0;
    cyc(4);
    chk(asleep, 0);
    m_delta <= 0;  // Host has read modem status
    cyc(3);
    chk(asleep, 1);
    // Start edge on the other channel wakes, low line keeps awake
    rx_pin_peer <= 0;
    cyc(2);
    chk(asleep, 0);
    {rx_pin_peer, peer_irq} <= 2'b11;
    cyc(3);
    chk(asleep, 0);
    peer_irq <= 0;
    cyc(3);
    chk(asleep, 1);
    peer_sleep_en <= 0;
    cyc(3);
    chk({asleep, osc_run}, 8'h01);
    $display("test sleep done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_pause();
    t_special();
    t_gen();
    t_ir();
    t_sleep();
    finish_test();
  end
  // Whole run is near 1000 cycles
  initial begin
    #50000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire

// ### bench/usf_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module usf_far_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Shifter handshake
  input  wire logic       sh_valid,
  input  wire logic [7:0] sh_data,
  output logic            sh_ready,
  // Traffic seen on the line
  output logic [7:0]      last_q,
  output logic [7:0]      cnt_q
);
  logic [1:0] lag_q;  // Cycles a char waits
  // ----------------------------------------
  // Slow shifter
  // ----------------------------------------
  // Never ready at once, so the offer must hold
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {sh_ready, lag_q, last_q, cnt_q} <= '0;
    end else if (sh_valid && sh_ready) begin
      sh_ready <= 1'b0;
      lag_q    <= 2'h0;
      last_q   <= sh_data;
      cnt_q    <= cnt_q + 8'h01;
    end else if (sh_valid) begin
      lag_q    <= lag_q + 2'h1;
      sh_ready <= (lag_q == 2'h2);
    end
  end
endmodule
`default_nettype wire

// ### design/usf_irda.sv
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"
module usf_irda
  import usf_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Control
  input  wire logic irda_en,
  input  wire logic rx_invert,
  input  wire logic baud16_tick,
  // Serial streams
  input  wire logic tx_nrz,
  input  wire logic tx_bit_start,
  input  wire logic rx_pin,
  output logic      tx_pin,
  output logic      rx_decoded
);
  logic [4:0] pulse_q;  // Remaining encoder pulse ticks
  logic [4:0] pulse_d;
  logic [4:0] str_q;    // Decoder stretch ticks
  logic       rx_lvl;   // Light level after polarity

  // Encoder pulse counter, restarted on each zero bit
  always_comb begin
    pulse_d = pulse_q;
    if (tx_bit_start && !tx_nrz) begin
      pulse_d = `USF_IR_TICKS;
    end else if (baud16_tick && pulse_q != 5'h00) begin
      pulse_d = pulse_q - 5'h01;
    end
  end

  // Inversion only applies to the codec path
  assign rx_lvl = rx_pin ^ rx_invert;

  // Pins and counters; reset leaves the IR rx side idle low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q    <= 5'h00;
      str_q      <= 5'h00;
      tx_pin     <= 1'b0;
      rx_decoded <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
      if (rx_lvl) begin
        str_q <= 5'(`USF_OVERS);
      end else if (baud16_tick && str_q != 5'h00) begin
        str_q <= str_q - 5'h01;
      end
      tx_pin     <= irda_en ? (pulse_d != 5'h00) : tx_nrz;
      rx_decoded <= irda_en ? (rx_lvl || str_q != 5'h00) : rx_pin;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_ir_pulse_len: assert property (irda_en && tx_bit_start && !tx_nrz |=> pulse_q == 5'h03 && tx_pin)
    else $error("ir pulse not started at 3 ticks");
  chk_ir_idle_low: assert property (irda_en && pulse_d == 5'h00 |=> !tx_pin)
    else $error("ir tx not idle low");
endmodule
`default_nettype wire

// ### design/usf_params.svh
// Behaviour
// - Pause match halts tx after current char
// - Pause match sets flag, irq if enabled
// - Resume match restarts tx, clears flag
// - Character registers reset to zero
// - Double mode matches two consecutive chars
// - Consumed flow chars never reach FIFO
// - Send pause two char times after trigger
// - Send resume at fill one level below
// - Special char still stored in FIFO
// - Special char match sets status flag
// - Compare only word length bits
// - Bit 0 matches first received bit
// - IR zero bit gives 3/16 high pulse
// - IR mode enables codec, tx idles low
// - IR rx idles low, pulse decodes high
// - Rx polarity inversion in IR mode
// - Sleep only when all idle conditions hold
// - Oscillator stopped while asleep
// - Wake on start edge, tx write, modem change
// - Re-sleep after service, never with irq
// - Auto sleep until sleep enable cleared
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH
// ----------------------------------------
// Character registers
// ----------------------------------------
`define USF_CHAR_RST   8'h00
`define USF_SEL_P1     2'h0
`define USF_SEL_P2     2'h1
`define USF_SEL_R1     2'h2
`define USF_SEL_R2     2'h3
// ----------------------------------------
// Fill levels, trigger and resume
// ----------------------------------------
`define USF_TRIG0      5'h01
`define USF_TRIG1      5'h04
`define USF_TRIG2      5'h08
`define USF_TRIG3      5'h0e
`define USF_RES0       5'h00
`define USF_RES1       5'h01
`define USF_RES2       5'h04
`define USF_RES3       5'h08
// ----------------------------------------
// Timing
// ----------------------------------------
`define USF_OVERS      16
`define USF_IR_TICKS   5'h03
`define USF_GAP_CHARS  2
`define USF_FRAME_BITS 5'h07
`endif

// ### design/usf_pkg.sv
package usf_pkg;
  // Flow control match or send mode; code 3 is illegal
  typedef enum logic [1:0] {USF_FC_OFF, USF_FC_SINGLE, USF_FC_DOUBLE} usf_fc_mode_t;
  // Pause generation state
  typedef enum logic [1:0] {GEN_IDLE, GEN_WAIT, GEN_PAUSED} usf_gen_t;
  // Sleep state
  typedef enum logic {SLP_AWAKE, SLP_ASLEEP} usf_slp_t;
endpackage

// ### design/usf_sleep.sv
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"
module usf_sleep
  import usf_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Enables and pending state of both channels
  input  wire logic sleep_en,
  input  wire logic peer_sleep_en,
  input  wire logic own_irq_pending,
  input  wire logic peer_irq_pending,
  input  wire logic modem_delta_any,
  input  wire logic tx_idle,
  // Wake sources
  input  wire logic rx_pin,
  input  wire logic rx_pin_peer,
  input  wire logic thr_write,
  input  wire logic modem_in_change,
  // Oscillator control
  output logic      osc_run,
  output logic      asleep
);
  usf_slp_t   slp_q;     // Sleep state
  logic [1:0] rx_prev_q; // Previous rx levels for start edges
  logic       wake;      // Any wake event
  logic       may_sleep; // All entry conditions

  // Falling rx edge, transmit write, modem change or enable drop
  assign wake = (rx_prev_q[0] && !rx_pin) || (rx_prev_q[1] && !rx_pin_peer) || thr_write
              || modem_in_change || !sleep_en || !peer_sleep_en;
  // Delta bits stay set until the host reads modem status
  assign may_sleep = sleep_en && peer_sleep_en && !own_irq_pending && !peer_irq_pending
                   && !modem_delta_any && rx_pin && rx_pin_peer && tx_idle && !wake;

  // Sleep state; this logic must sit on a clock that never stops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slp_q     <= SLP_AWAKE;
      rx_prev_q <= 2'h3;
      osc_run   <= 1'b1;
      asleep    <= 1'b0;
    end else begin
      rx_prev_q <= {rx_pin_peer, rx_pin};
      unique case (slp_q)
        SLP_AWAKE: begin
          if (may_sleep) begin
            slp_q   <= SLP_ASLEEP;
            osc_run <= 1'b0;
            asleep  <= 1'b1;
          end
        end
        SLP_ASLEEP: begin
          if (wake) begin
            slp_q   <= SLP_AWAKE;
            osc_run <= 1'b1;
            asleep  <= 1'b0;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_no_irq_sleep: assert property ($rose(asleep) |-> !$past(own_irq_pending) && !$past(peer_irq_pending))
    else $error("sleep entered with irq pending");
  chk_wake_write: assert property (asleep && thr_write |=> !asleep && osc_run)
    else $error("no wake on transmit write");
  chk_osc_stop: assert property (asleep |-> !osc_run ##1 (asleep || osc_run))
    else $error("oscillator runs while asleep");
  cov_sleep_wake: cover property ($rose(asleep) ##[1:50] $fell(asleep));
endmodule
`default_nettype wire

// ### design/usf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"
module usf_top
  import usf_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Flow control configuration
  input  var  usf_fc_mode_t rx_fc_mode,
  input  var  usf_fc_mode_t tx_fc_mode,
  input  wire logic         special_det_en,
  input  wire logic         pause_irq_en,
  input  wire logic [1:0]   word_len,
  input  wire logic [1:0]   rx_trig_sel,
  // Infrared configuration
  input  wire logic         irda_en,
  input  wire logic         rx_invert,
  // Character register write port
  input  wire logic         char_wr,
  input  wire logic [1:0]   char_sel,
  input  wire logic [7:0]   char_wdata,
  // Status
  input  wire logic         flag_clr,
  output logic              pause_flag,
  output logic              pause_irq,
  output logic              tx_halted,
  // Receiver side
  input  wire logic         rx_char_valid,
  input  wire logic [7:0]   rx_char,
  input  wire logic [4:0]   rx_fill,
  output logic              rxf_push,
  output logic [7:0]        rxf_data,
  // Transmit FIFO side
  input  wire logic         txf_valid,
  input  wire logic [7:0]   txf_data,
  output logic              txf_pop,
  // Transmit shifter side
  input  wire logic         sh_ready,
  input  wire logic         baud16_tick,
  input  wire logic         tx_nrz,
  input  wire logic         tx_bit_start,
  output logic              sh_valid,
  output logic [7:0]        sh_data,
  // Serial pins
  input  wire logic         rx_pin,
  output logic              tx_pin,
  output logic              rx_decoded,
  // Sleep
  input  wire logic         sleep_en,
  input  wire logic         peer_sleep_en,
  input  wire logic         own_irq_pending,
  input  wire logic         peer_irq_pending,
  input  wire logic         modem_delta_any,
  input  wire logic         rx_pin_peer,
  input  wire logic         thr_write,
  input  wire logic         modem_in_change,
  input  wire logic         tx_idle,
  output logic              osc_run,
  output logic              asleep
);
  // ----------------------------------------
  // Character registers and matching
  // ----------------------------------------
  logic [7:0] chr_q [4];  // Pause 1, pause 2, resume 1, resume 2
  logic       hit_p1;     // Match flags for the current char
  logic       hit_p2;
  logic       hit_r1;
  logic       hit_r2;
  logic       spec_hit;   // Special character seen

  // Masked compare; bit 0 is the first bit on the line
  function automatic logic chr_eq(input logic [7:0] a, input logic [7:0] b, input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - wl);
    return ((a ^ b) & m) == 8'h00;
  endfunction

  // Host writes; reset values are zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        chr_q[i] <= `USF_CHAR_RST;
      end
    end else if (char_wr) begin
      chr_q[char_sel] <= char_wdata;
    end
  end

  assign hit_p1   = chr_eq(rx_char, chr_q[`USF_SEL_P1], word_len);
  assign hit_p2   = chr_eq(rx_char, chr_q[`USF_SEL_P2], word_len);
  assign hit_r1   = chr_eq(rx_char, chr_q[`USF_SEL_R1], word_len);
  assign hit_r2   = chr_eq(rx_char, chr_q[`USF_SEL_R2], word_len);
  assign spec_hit = special_det_en && hit_p2;

  // ----------------------------------------
  // Receive filter
  // ----------------------------------------
  logic       hold_q;      // First char of a pair held back
  logic       hkind_q;     // Held kind, 1 for resume
  logic [7:0] hdata_q;     // Held char
  logic       late_q;      // Char deferred one cycle
  logic [7:0] late_data_q;
  logic       hold_d;
  logic       hkind_d;
  logic [7:0] hdata_d;
  logic       late_d;
  logic       push_d;
  logic [7:0] pdata_d;
  logic       do_pause;    // Pause sequence matched
  logic       do_resume;   // Resume sequence matched

  // Decide per char: store, hold, or consume
  always_comb begin
    push_d    = late_q;
    pdata_d   = late_data_q;
    hold_d    = hold_q;
    hkind_d   = hkind_q;
    hdata_d   = hdata_q;
    late_d    = 1'b0;
    do_pause  = 1'b0;
    do_resume = 1'b0;
    if (rx_char_valid) begin
      if (spec_hit || rx_fc_mode == USF_FC_OFF) begin
        // Special char is data as well as an event
        push_d  = 1'b1;
        pdata_d = rx_char;
      end else if (rx_fc_mode == USF_FC_SINGLE) begin
        if (hit_p1) begin
          do_pause = 1'b1;
        end else if (hit_r1) begin
          do_resume = 1'b1;
        end else begin
          push_d  = 1'b1;
          pdata_d = rx_char;
        end
      end else if (hold_q && (hkind_q ? hit_r2 : hit_p2)) begin
        // Second of a pair completes; both chars dropped
        do_pause  = !hkind_q;
        do_resume = hkind_q;
        hold_d    = 1'b0;
      end else begin
        // Broken pair: held char becomes data
        if (hold_q) begin
          push_d  = 1'b1;
          pdata_d = hdata_q;
        end
        hold_d  = hit_p1 || hit_r1;
        hkind_d = !hit_p1;
        hdata_d = rx_char;
        if (!(hit_p1 || hit_r1)) begin
          if (hold_q) begin
            late_d = 1'b1;
          end else begin
            push_d  = 1'b1;
            pdata_d = rx_char;
          end
        end
      end
    end
  end

  // Filter registers and FIFO push
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q      <= 1'b0;
      hkind_q     <= 1'b0;
      hdata_q     <= 8'h00;
      late_q      <= 1'b0;
      late_data_q <= 8'h00;
      rxf_push    <= 1'b0;
      rxf_data    <= 8'h00;
    end else begin
      hold_q      <= hold_d && (rx_fc_mode == USF_FC_DOUBLE);
      hkind_q     <= hkind_d;
      hdata_q     <= hdata_d;
      late_q      <= late_d;
      late_data_q <= late_d ? rx_char : late_data_q;
      rxf_push    <= push_d;
      rxf_data    <= pdata_d;
    end
  end

  // Flag, halt and interrupt; a set beats a clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pause_flag <= 1'b0;
      tx_halted  <= 1'b0;
      pause_irq  <= 1'b0;
    end else begin
      if (do_pause || (rx_char_valid && spec_hit)) begin
        pause_flag <= 1'b1;
      end else if (do_resume || flag_clr) begin
        pause_flag <= 1'b0;
      end
      if (do_pause) begin
        tx_halted <= 1'b1;
      end else if (do_resume || rx_fc_mode == USF_FC_OFF) begin
        tx_halted <= 1'b0;
      end
      pause_irq <= pause_flag && pause_irq_en;
    end
  end

  // ----------------------------------------
  // Pause and resume generation
  // ----------------------------------------
  usf_gen_t   gen_q;
  logic [9:0] gap_q;      // Ticks left before pause goes out
  logic [9:0] gap_ticks;  // Two char times in 16x ticks
  logic [4:0] trig_lvl;
  logic [4:0] res_lvl;
  logic [1:0] fc_pend_q;  // Flow chars still to send
  logic       fc_kind_q;  // 1 for resume
  logic       fc_idx_q;   // Second char of a pair
  logic       req_pause;
  logic       req_resume;

  // Fill level table lookup
  function automatic logic [4:0] lvl(input logic [1:0] sel, input logic res);
    logic [4:0] t;
    unique case (sel)
      2'h0: t = res ? `USF_RES0 : `USF_TRIG0;
      2'h1: t = res ? `USF_RES1 : `USF_TRIG1;
      2'h2: t = res ? `USF_RES2 : `USF_TRIG2;
      2'h3: t = res ? `USF_RES3 : `USF_TRIG3;
    endcase
    return t;
  endfunction

  assign trig_lvl  = lvl(rx_trig_sel, 1'b0);
  assign res_lvl   = lvl(rx_trig_sel, 1'b1);
  // Start, data and stop bits, no parity counted
  assign gap_ticks = 10'(`USF_FRAME_BITS + 5'(word_len)) * 10'(`USF_GAP_CHARS * `USF_OVERS);
  assign req_pause = tx_fc_mode != USF_FC_OFF && gen_q == GEN_WAIT && gap_q == 10'h000
                   && fc_pend_q == 2'h0 && rx_fill > res_lvl;
  assign req_resume = tx_fc_mode != USF_FC_OFF && gen_q == GEN_PAUSED && rx_fill <= res_lvl
                    && fc_pend_q == 2'h0;

  // Fill watcher
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gen_q <= GEN_IDLE;
      gap_q <= 10'h000;
    end else if (tx_fc_mode == USF_FC_OFF) begin
      gen_q <= GEN_IDLE;
    end else begin
      unique case (gen_q)
        GEN_IDLE: begin
          if (rx_fill >= trig_lvl) begin
            gen_q <= GEN_WAIT;
            gap_q <= gap_ticks;
          end
        end
        GEN_WAIT: begin
          if (rx_fill <= res_lvl) begin
            gen_q <= GEN_IDLE;
          end else if (req_pause) begin
            gen_q <= GEN_PAUSED;
          end else if (baud16_tick && gap_q != 10'h000) begin
            gap_q <= gap_q - 10'h001;
          end
        end
        GEN_PAUSED: begin
          if (req_resume) begin
            gen_q <= GEN_IDLE;
          end
        end
        default: gen_q <= GEN_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit arbiter
  // ----------------------------------------
  // Only loads when the shifter slot is free, so nothing is cut off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fc_pend_q <= 2'h0;
      fc_kind_q <= 1'b0;
      fc_idx_q  <= 1'b0;
      sh_valid  <= 1'b0;
      sh_data   <= 8'h00;
      txf_pop   <= 1'b0;
    end else begin
      txf_pop <= 1'b0;
      if (sh_valid && sh_ready) begin
        sh_valid <= 1'b0;
      end
      if (req_pause || req_resume) begin
        fc_pend_q <= (tx_fc_mode == USF_FC_DOUBLE) ? 2'h2 : 2'h1;
        fc_kind_q <= req_resume;
        fc_idx_q  <= 1'b0;
      end else if (!sh_valid && !txf_pop && fc_pend_q != 2'h0) begin
        // Select order matches pause/resume, first/second
        sh_valid  <= 1'b1;
        sh_data   <= chr_q[{fc_kind_q, fc_idx_q}];
        fc_pend_q <= fc_pend_q - 2'h1;
        fc_idx_q  <= 1'b1;
      end else if (!sh_valid && !txf_pop && txf_valid && !tx_halted) begin
        sh_valid <= 1'b1;
        sh_data  <= txf_data;
        txf_pop  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Infrared codec and sleep control
  // ----------------------------------------
  usf_irda u_irda (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .irda_en     (irda_en),
    .rx_invert   (rx_invert),
    .baud16_tick (baud16_tick),
    .tx_nrz      (tx_nrz),
    .tx_bit_start(tx_bit_start),
    .rx_pin      (rx_pin),
    .tx_pin      (tx_pin),
    .rx_decoded  (rx_decoded)
  );

  usf_sleep u_sleep (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .sleep_en        (sleep_en),
    .peer_sleep_en   (peer_sleep_en),
    .own_irq_pending (own_irq_pending),
    .peer_irq_pending(peer_irq_pending),
    .modem_delta_any (modem_delta_any),
    .tx_idle         (tx_idle),
    .rx_pin          (rx_pin),
    .rx_pin_peer     (rx_pin_peer),
    .thr_write       (thr_write),
    .modem_in_change (modem_in_change),
    .osc_run         (osc_run),
    .asleep          (asleep)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_pause_halts: assert property (do_pause |=> tx_halted ##1 (!txf_pop || $past(fc_pend_q) != 2'h0))
    else $error("tx not halted after pause");
  chk_pause_irq: assert property (do_pause && pause_irq_en ##1 pause_irq_en |-> ##1 pause_irq)
    else $error("pause irq missing");
  chk_resume_runs: assert property (do_resume && !do_pause |=> !tx_halted && !pause_flag)
    else $error("resume did not restart");
  chk_char_reset: assert property ($rose(nrst) |-> chr_q[0] == 8'h00 && chr_q[3] == 8'h00)
    else $error("char regs not cleared");
  chk_flow_dropped: assert property (rx_char_valid && rx_fc_mode == USF_FC_SINGLE && !spec_hit
                                     && hit_p1 && !late_q |=> !rxf_push)
    else $error("flow char stored");
  chk_spec_stored: assert property (rx_char_valid && spec_hit && !late_q |=> rxf_push && rxf_data == $past(rx_char)
                                    && pause_flag)
    else $error("special char lost");
  chk_gap_load: assert property ($rose(gen_q == GEN_WAIT) |-> gap_q == $past(gap_ticks))
    else $error("gap count wrong");
  chk_resume_send: assert property (req_resume |=> fc_pend_q != 2'h0 && fc_kind_q ##[1:20] sh_valid)
    else $error("resume not sent");
  cov_pause_rx: cover property (do_pause ##[1:200] do_resume);
  cov_pause_tx: cover property (req_pause ##[1:20] sh_valid);
  cov_double: cover property (rx_fc_mode == USF_FC_DOUBLE && do_pause);
endmodule
`default_nettype wire
